// >>> rtl/spmsp_consts.svh
// register offsets, field positions and rate figures of the serial port
`ifndef SPMSP_CONSTS_SVH
`define SPMSP_CONSTS_SVH
`define SPMSP_IDX_CTRL 8'h0D
`define SPMSP_IDX_STAT 8'h0E
`define SPMSP_IDX_DATA 8'h0F
`define SPMSP_ADDR_CTRL (12'(`SPMSP_IDX_CTRL) << 2)
`define SPMSP_ADDR_STAT (12'(`SPMSP_IDX_STAT) << 2)
`define SPMSP_ADDR_DATA (12'(`SPMSP_IDX_DATA) << 2)
`define SPMSP_CTRL_RESET 8'h00
`define SPMSP_BIT_IRQ_EN 7
`define SPMSP_BIT_PORT_EN 6
`define SPMSP_BIT_ORDER 5
`define SPMSP_BIT_CTL_SEL 4
`define SPMSP_BIT_IDLE_LVL 3
`define SPMSP_BIT_PHASE 2
`define SPMSP_BIT_DONE 7
`define SPMSP_BIT_CLASH 6
`define SPMSP_DIV_0 8'h04
`define SPMSP_DIV_1 8'h10
`define SPMSP_DIV_2 8'h40
`define SPMSP_DIV_3 8'h80
`define SPMSP_EDGES_LAST 4'hF
`endif

// >>> rtl/spmsp_pkg.sv
// types shared by the serial port block
package spmsp_pkg;
  // transfer engine phase
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} xfer_e;
  // pin drive towards the pads
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
  } pin_out_s;
  // user pin direction settings, one means output, and ss_val, the ss output level
  typedef struct packed {
    logic sck_dir;
    logic mosi_dir;
    logic miso_dir;
    logic ss_dir;
    logic ss_val;
  } pin_dir_s;
  // whole state of the port
  typedef struct packed {
    logic [7:0] ctrl;
    logic done;
    logic clash;
    logic armed;
    logic [7:0] rxbuf;
    logic [7:0] shreg;
    logic samp;
    logic [3:0] ecnt;
    logic [6:0] div;
    logic sck;
    logic prev_sck;
    xfer_e st;
  } state_s;
endpackage : spmsp_pkg

// >>> rtl/spmsp_top.sv
// byte serial port, controller or target, with an apb register slave
`include "spmsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spmsp_top (
  // clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins, sampled synchronously
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  input wire logic ss_in_n,
  output spmsp_pkg::pin_out_s pins,
  // user direction settings and system side
  input wire spmsp_pkg::pin_dir_s dirs,
  input wire logic global_irq_en,
  input wire logic irq_taken,
  output logic irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // shift one bit into the byte in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic lsbf);
    shift_in = lsbf ? {d, b[7:1]} : {b[6:0], d};
  endfunction : shift_in

  // bit currently presented on the data line
  function automatic logic out_bit(input logic [7:0] b, input logic lsbf);
    out_bit = lsbf ? b[0] : b[7];
  endfunction : out_bit

  // ----------------------------------------
  // decode
  // ----------------------------------------

  spmsp_pkg::state_s s; // registered state
  spmsp_pkg::state_s next_s; // next state
  logic acc; // apb access completes this edge
  logic hit_ctrl; // address decodes
  logic hit_stat;
  logic hit_data;
  logic en; // port enabled
  logic ctl; // controller mode
  logic lsbf; // lsb first
  logic clock_idle_level; // idle clock level
  logic clock_phase_select; // sample on trailing edge
  logic fault; // ss pulled low on a controller
  logic tgt_act; // target selected
  logic [6:0] half; // half period in clocks

  assign hit_ctrl = paddr == `SPMSP_ADDR_CTRL;
  assign hit_stat = paddr == `SPMSP_ADDR_STAT;
  assign hit_data = paddr == `SPMSP_ADDR_DATA;
  // wait states only while the clock enable holds the block frozen
  assign pready = pclken;
  assign acc = psel && penable && pclken;
  assign pslverr = psel && penable && !(hit_ctrl || hit_stat || hit_data);
  assign en = s.ctrl[`SPMSP_BIT_PORT_EN];
  assign ctl = s.ctrl[`SPMSP_BIT_CTL_SEL];
  assign lsbf = s.ctrl[`SPMSP_BIT_ORDER];
  assign clock_idle_level = s.ctrl[`SPMSP_BIT_IDLE_LVL];
  assign clock_phase_select = s.ctrl[`SPMSP_BIT_PHASE];
  assign fault = en && ctl && !dirs.ss_dir && !ss_in_n;
  assign tgt_act = en && !ctl && !ss_in_n;

  // rate bits choose the divisor, halved for each sck phase
  always_comb begin
    case (s.ctrl[1:0])
      2'b00: half = 7'(`SPMSP_DIV_0 >> 1);
      2'b01: half = 7'(`SPMSP_DIV_1 >> 1);
      2'b10: half = 7'(`SPMSP_DIV_2 >> 1);
      default: half = 7'(`SPMSP_DIV_3 >> 1);
    endcase
  end

  // ----------------------------------------
  // register read side
  // ----------------------------------------

  // reads are combinational from flops so the slave answers with no wait while pclken is high
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata[7:0] = s.ctrl;
    end else if (hit_stat) begin
      // low six bits stay zero
      prdata[7:0] = {s.done, s.clash, 6'h00};
    end else if (hit_data) begin
      prdata[7:0] = s.rxbuf;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------

  // engine, flags and registers in one place so every priority is visible
  always_comb begin
    logic lead;
    logic trail;
    logic din;
    logic smp;
    logic shf;
    logic fin;
    logic set_done;
    logic clr_flags;
    logic dwr;
    next_s = s;
    lead = 1'b0;
    trail = 1'b0;
    din = 1'b0;
    smp = 1'b0;
    shf = 1'b0;
    fin = 1'b0;
    set_done = 1'b0;
    clr_flags = 1'b0;
    dwr = acc && pwrite && hit_data;
    next_s.prev_sck = sck_in;

    // control register write; the fault below may still clear select
    if (acc && pwrite && hit_ctrl) begin
      next_s.ctrl = pwdata[7:0];
    end

    // status read arms the flag clear, data access fires it
    if (acc && !pwrite && hit_stat) begin
      next_s.armed = s.done || s.clash;
    end
    if (acc && hit_data && s.armed) begin
      clr_flags = 1'b1;
      next_s.armed = 1'b0;
    end

    // edge finder for both modes
    if (en && ctl && s.st == spmsp_pkg::ST_RUN) begin
      // clock generator toggles sck every half period
      if (s.div == half - 7'h01) begin
        next_s.div = 7'h00;
        next_s.sck = !s.sck;
        lead = !s.ecnt[0];
        trail = s.ecnt[0];
      end else begin
        next_s.div = s.div + 7'h01;
      end
      din = miso_in;
    end else if (tgt_act) begin
      // target follows the external clock
      lead = s.prev_sck == clock_idle_level && sck_in != clock_idle_level;
      trail = s.prev_sck != clock_idle_level && sck_in == clock_idle_level;
      din = mosi_in;
    end

    // phase picks the sampling and shifting edges
    smp = clock_phase_select ? trail : lead;
    shf = clock_phase_select ? (lead && s.ecnt != 4'h0) : trail;
    if (smp) begin
      next_s.samp = din;
    end
    if (lead || trail) begin
      next_s.ecnt = s.ecnt + 4'h1;
      fin = s.ecnt == `SPMSP_EDGES_LAST;
    end
    if (shf) begin
      // ring shift: out goes the presented bit, in comes the sample
      next_s.shreg = shift_in(s.shreg, s.samp, lsbf);
    end

    // byte complete: result moves to the receive buffer
    if (fin) begin
      next_s.shreg = clock_phase_select ? shift_in(s.shreg, din, lsbf) : shift_in(s.shreg, s.samp, lsbf);
      next_s.rxbuf = next_s.shreg;
      next_s.st = spmsp_pkg::ST_IDLE;
      next_s.ecnt = 4'h0;
      set_done = 1'b1;
    end

    // data write: load when idle, else flag the clash and drop it
    if (dwr) begin
      if (s.st == spmsp_pkg::ST_RUN || s.ecnt != 4'h0) begin
        next_s.clash = 1'b1;
      end else begin
        next_s.shreg = pwdata[7:0];
        if (en && ctl) begin
          next_s.st = spmsp_pkg::ST_RUN;
          next_s.div = 7'h00;
          next_s.sck = clock_idle_level;
        end
      end
    end

    // target deselected: serial logic back to the start
    if (!en || ss_in_n && !ctl) begin
      next_s.ecnt = 4'h0;
      next_s.st = spmsp_pkg::ST_IDLE;
    end

    // ss fault demotes to target; software must reselect
    if (fault) begin
      next_s.ctrl[`SPMSP_BIT_CTL_SEL] = 1'b0;
      next_s.st = spmsp_pkg::ST_IDLE;
      next_s.ecnt = 4'h0;
      set_done = 1'b1;
    end

    // flag update, a new event beats a clear in the same cycle
    if (clr_flags || irq_taken) begin
      next_s.done = 1'b0;
    end
    if (clr_flags) begin
      next_s.clash = dwr && next_s.clash && !s.armed ? 1'b1 : 1'b0;
      if (dwr && (s.st == spmsp_pkg::ST_RUN || s.ecnt != 4'h0)) begin
        next_s.clash = 1'b1;
      end
    end
    if (set_done) begin
      next_s.done = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------

  // one flop bank; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{ctrl: `SPMSP_CTRL_RESET, st: spmsp_pkg::ST_IDLE, default: '0};
    end else if (pclken) begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // pins and interrupt
  // ----------------------------------------

  // directions forced by mode while enabled; disabled releases every pad
  always_comb begin
    pins = '0;
    if (en && ctl) begin
      pins.sck_oe = dirs.sck_dir;
      pins.sck_o = s.st == spmsp_pkg::ST_RUN ? s.sck : clock_idle_level;
      pins.mosi_oe = dirs.mosi_dir;
      pins.mosi_o = out_bit(s.shreg, lsbf);
      pins.ss_oe = dirs.ss_dir;
      pins.ss_o = dirs.ss_val;
    end else if (tgt_act) begin
      // only miso may drive, and only while selected
      pins.miso_oe = dirs.miso_dir;
      pins.miso_o = out_bit(s.shreg, lsbf);
    end
  end

  assign irq = s.done && s.ctrl[`SPMSP_BIT_IRQ_EN] && global_irq_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence start_seq;
    pclken && acc && pwrite && hit_data && en && ctl && s.st == spmsp_pkg::ST_IDLE && s.ecnt == 4'h0 && !fault;
  endsequence

  sequence run_seq;
    s.st == spmsp_pkg::ST_RUN;
  endsequence

  start_runs_a: assert property (start_seq |=> run_seq)
    else $error("data write did not start a transfer");
  clash_set_a: assert property (pclken && acc && pwrite && hit_data && s.st == spmsp_pkg::ST_RUN |=> s.clash)
    else $error("write during transfer left clash clear");
  fault_demote_a: assert property (pclken && fault |=> !ctl && s.done && s.st == spmsp_pkg::ST_IDLE)
    else $error("ss fault did not demote controller");
  irq_cause_a: assert property (irq |-> s.done && global_irq_en)
    else $error("interrupt without done flag");
  stat_zero_a: assert property (psel && hit_stat |-> prdata[5:0] == 6'h00)
    else $error("reserved status bits not zero");
  sck_idle_a: assert property (en && ctl && s.st == spmsp_pkg::ST_IDLE |-> pins.sck_o == clock_idle_level)
    else $error("sck not at idle level");
  disabled_quiet_a: assert property (pclken && !$past(en) && !en |-> s.st == spmsp_pkg::ST_IDLE && pins == '0)
    else $error("activity while port disabled");
  ss_reset_a: assert property (pclken && en && !ctl && ss_in_n |=> s.ecnt == 4'h0)
    else $error("target logic not reset by ss high");
  miso_in_a: assert property (ctl |-> !pins.miso_oe)
    else $error("controller drives miso");
  byte_end_a: assert property (run_seq ##1 s.st == spmsp_pkg::ST_IDLE && $past(s.ecnt) == `SPMSP_EDGES_LAST
    |-> s.done)
    else $error("byte ended without done flag");

endmodule : spmsp_top
`default_nettype wire

// >>> tb/spmsp_target_model.sv
// behavioural far-side target device for the serial port bench
`timescale 1ns/1ps
`default_nettype none
module spmsp_target_model (
  // serial lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // bench side
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh; // outgoing byte
  logic psck = 1'h0; // last seen clock level
  logic nxt; // bit now on the line
  // mode zero only: sample on rising, shift on falling, reload while deselected
  always @(sck or sel_n or tx_byte) begin
    if (sel_n) begin
      sh = tx_byte; // deselect drops any partial byte
    end else if (sck && !psck) begin
      rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi}; // ring half
    end else if (!sck && psck) begin
      sh = lsb_first ? {1'h0, sh[7:1]} : {sh[6:0], 1'h0}; // trailing edge shift
    end
    psck = sck;
  end
  assign nxt = lsb_first ? sh[0] : sh[7];
  // released line shows the inverse, so a stale bit can never pass for data
  assign miso = sel_n ? ~nxt : nxt;
endmodule : spmsp_target_model
`default_nettype wire

// >>> tb/spmsp_top_tb.sv
// self-checking bench for the serial port block
`include "spmsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spmsp_top_tb;
  // clock, reset and apb
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic pclken = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, miso, err;
  // system side and far side
  logic ss_in_n = 1'h1;
  logic global_irq_en = 1'h1;
  logic irq_taken = 1'h0;
  spmsp_pkg::pin_out_s pins;
  spmsp_pkg::pin_dir_s dirs = 5'h1B; // sck, mosi, ss out; ss high
  logic lsb = 1'h0;
  logic [7:0] tgt_tx = 8'h3C;
  logic [7:0] tgt_rx, q;
  logic tsck = 1'h0; // bench-made clock for target mode
  logic tmosi = 1'h0; // bench-made data for target mode
  logic [7:0] tq = 8'h00; // bits collected from miso in target mode
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;

  always #2.5 pclk = ~pclk;

  spmsp_top spmsp_top_inst (.pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck_in(tsck), .mosi_in(tmosi), .miso_in(miso), .ss_in_n, .pins,
    .dirs, .global_irq_en, .irq_taken, .irq);
  spmsp_target_model spmsp_target_model_inst (.sck(pins.sck_o), .mosi(pins.mosi_o), .sel_n(pins.ss_o),
    .miso, .lsb_first(lsb), .tx_byte(tgt_tx), .rx_byte(tgt_rx));

  // byte compare, counts every call
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp
  // one apb transfer, then an idle edge so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    apb(1'h0, a, 8'h00);
    cmp(what, exp, q);
  endtask : rd
  // poll status until done; the bench timeout bounds it
  task automatic wait_done();
    apb(1'h0, `SPMSP_ADDR_STAT, 8'h00);
    while (q[7] !== 1'h1) begin
      apb(1'h0, `SPMSP_ADDR_STAT, 8'h00);
    end
  endtask : wait_done
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(`SPMSP_ADDR_CTRL, 8'h00, "control reset");
    rd(`SPMSP_ADDR_STAT, 8'h00, "status reset");
    apb(1'h0, 12'h040, 8'h00);
    cmp("unmapped error", 8'h01, {7'h0, err});
    // disabled port: a data write must not start anything
    apb(1'h1, `SPMSP_ADDR_CTRL, 8'h10);
    apb(1'h1, `SPMSP_ADDR_DATA, 8'h55);
    repeat (40) @(posedge pclk);
    rd(`SPMSP_ADDR_STAT, 8'h00, "status when disabled");
    // enabled controller, idle level high
    apb(1'h1, `SPMSP_ADDR_CTRL, 8'h58);
    @(negedge pclk);
    cmp("sck idle", 8'h01, {7'h0, pins.sck_o});
    cmp("pin drive", 8'h0D, {4'h0, pins.sck_oe, pins.mosi_oe, pins.miso_oe, pins.ss_oe});
    cmp("ss plain output", 8'h01, {7'h0, pins.ss_o});
    @(posedge pclk);
    // msb first at divide by 4, with a write clash mid-byte
    // drop the idle level while the model is still deselected, so no false edge shifts it
    apb(1'h1, `SPMSP_ADDR_CTRL, 8'h50);
    dirs.ss_val <= 1'h0;
    apb(1'h1, `SPMSP_ADDR_CTRL, 8'hD0);
    apb(1'h1, `SPMSP_ADDR_DATA, 8'hA5);
    apb(1'h1, `SPMSP_ADDR_DATA, 8'h11);
    wait_done();
    cmp("status after byte", 8'hC0, q);
    cmp("irq raised", 8'h01, {7'h0, irq});
    cmp("target received", 8'hA5, tgt_rx);
    rd(`SPMSP_ADDR_DATA, 8'h3C, "received byte");
    rd(`SPMSP_ADDR_STAT, 8'h00, "flags cleared");
    cmp("irq dropped", 8'h00, {7'h0, irq});
    // lsb first at divide by 16, cleared by the vector
    dirs.ss_val <= 1'h1;
    lsb <= 1'h1;
    tgt_tx <= 8'h96;
    repeat (3) @(posedge pclk);
    dirs.ss_val <= 1'h0;
    apb(1'h1, `SPMSP_ADDR_CTRL, 8'hF1);
    t0 = cyc;
    apb(1'h1, `SPMSP_ADDR_DATA, 8'h69);
    wait_done();
    cmp("byte time", 8'h01, {7'h0, cyc - t0 >= 128 && cyc - t0 <= 140});
    cmp("target received lsb", 8'h69, tgt_rx);
    global_irq_en <= 1'h0;
    @(negedge pclk);
    cmp("irq gated", 8'h00, {7'h0, irq});
    @(posedge pclk);
    global_irq_en <= 1'h1;
    irq_taken <= 1'h1;
    @(posedge pclk);
    irq_taken <= 1'h0;
    @(posedge pclk);
    rd(`SPMSP_ADDR_STAT, 8'h00, "done cleared by vector");
    rd(`SPMSP_ADDR_DATA, 8'h96, "received lsb byte");
    // ss input pulled low while controller
    dirs.ss_dir <= 1'h0;
    ss_in_n <= 1'h0;
    apb(1'h1, `SPMSP_ADDR_CTRL, 8'h50);
    repeat (4) @(posedge pclk);
    rd(`SPMSP_ADDR_CTRL, 8'h40, "select after fault");
    rd(`SPMSP_ADDR_STAT, 8'h80, "done after fault");
    @(negedge pclk);
    cmp("clock and data released", 8'h00, {6'h0, pins.sck_oe, pins.mosi_oe});
    @(posedge pclk);
    ss_in_n <= 1'h1;
    repeat (4) @(posedge pclk);
    rd(`SPMSP_ADDR_CTRL, 8'h40, "select stays clear");
    // target mode, phase zero: the bench clocks a byte in and collects miso
    dirs.miso_dir <= 1'h1;
    ss_in_n <= 1'h0;
    apb(1'h1, `SPMSP_ADDR_DATA, 8'hC3);
    cmp("target miso drive", 8'h01, {7'h0, pins.miso_oe});
    for (int i = 0; i < 8; i++) begin
      tmosi <= 8'h5A >> (7 - i);
      repeat (2) @(posedge pclk);
      tq = {tq[6:0], pins.miso_o};
      tsck <= 1'h1;
      repeat (2) @(posedge pclk);
      tsck <= 1'h0;
    end
    repeat (4) @(posedge pclk);
    cmp("target sent", 8'hC3, tq);
    rd(`SPMSP_ADDR_STAT, 8'h80, "target done");
    rd(`SPMSP_ADDR_DATA, 8'h5A, "target received");
    end_of_test();
  end
endmodule : spmsp_top_tb
`default_nettype wire
